// ==== inc/char_lcd_map.svh ====
// Constants of the character display host register port: field positions,
// reset values, address layout and timing counts.
// Assumes a 200 MHz core clock; included by bare name by the host register port design file.
`ifndef CHAR_LCD_MAP_SVH
`define CHAR_LCD_MAP_SVH

// ------------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------------
`define CLK_PERIOD_NS    5
`define EXEC_TIME_NS     40
`define EXEC_CYCLES      ((`EXEC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ------------------------------------------------------------------------
// Status byte and command fields
// ------------------------------------------------------------------------
`define BUSY_BIT         7
`define CMD_DRAM_BIT     7
`define CMD_GRAM_BIT     6
`define CMD_SHIFT_BIT    4
`define SHIFT_DISP_BIT   3
`define SHIFT_RIGHT_BIT  2
`define CMD_ENTRY_BIT    2
`define ENTRY_INC_BIT    1

// ------------------------------------------------------------------------
// Address layout and reset values
// ------------------------------------------------------------------------
`define LINE_LEN         6'h28
`define DRAM_LAST1       7'h27
`define DRAM_LINE2       7'h40
`define DRAM_LAST2       7'h67
`define DRAM_WORDS       80
`define GRAM_WORDS       64
`define FIFO_DEPTH       8
`define AC_RESET         7'h00
`define ENTRY_INC_RESET  1'b1
`define SHIFT_RESET      6'h00

`endif

// ==== inc/char_lcd_pkg.sv ====
// Types shared by the character display host register port.
// Assumes nothing of its surroundings.
package char_lcd_pkg;

   // Engine states, one-hot.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_EXEC  = 3'b010,
      ST_FETCH = 3'b100
   } eng_state_t;

   // Kind of host operation queued for the engine.
   typedef enum logic [1:0] {
      OP_CMD      = 2'h0,
      OP_DATA_WR  = 2'h1,
      OP_READ_ADV = 2'h2
   } op_kind_t;

   // One queued host operation.
   typedef struct packed {
      op_kind_t   kind;
      logic [7:0] value;
   } host_op_t;

endpackage

// ==== core/char_lcd_host_register_port.sv ====
// Host register port of a character display controller with its RAMs.
// Assumes host pins synchronous to clk_i; the data bus is split into
// input, output and active-low output enable lines joined outside.
`timescale 1ns/1ps
`default_nettype none
`include "char_lcd_map.svh"

// ------------------------------------------------------------------------
// Operation queue
// ------------------------------------------------------------------------
module op_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   // Filling side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Draining side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             push, pop;

   // Handshakes follow the fill level directly.
   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Pointer and level arithmetic; pointers wrap at the depth.
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   // Registers; the storage itself needs no reset.
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule // op_fifo

// Notes on behaviour
// - Two host registers of eight bits: command register and data register.
// - Command register is write only; takes commands and RAM addresses.
// - A data write is stored at the addressed RAM location automatically.
// - Writing an address prefetches that RAM byte into the data register.
// - Each data read reloads the data register from the next address.
// - Select/direction 00 command, 01 status, 10 data write, 11 data read.
// - While busy the status shows busy and commands are refused.
// - Address commands load the counter and pick display or glyph RAM.
// - Counter steps by one after each data access, per entry direction.
// - Display RAM holds 80 bytes; unseen locations stay usable storage.
// - Display address is seven bits, set by command, read with status.
// - Unshifted, positions map to 00H-0FH and 40H-4FH.
// - Display shift moves the visible window one address left or right.
// - Fixed glyph table turns codes into dots: 208 small, 32 tall.
// - Writes latch on strobe fall; reads drive the bus while strobe high.
// - Four-bit mode uses only the upper four lines for both halves.
// - Select high means data, low command; direction high read, low write.
module char_lcd_host_register_port
   import char_lcd_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // Host pins
   input  wire logic       register_select_line_i,
   input  wire logic       read_not_write_i,
   input  wire logic       strobe_i,
   input  wire logic [7:0] bus_i,
   output logic      [7:0] bus_o,
   output logic      [7:0] bus_oe_b_o,
   // Bus width strap, high for four-bit transfers
   input  wire logic       four_bit_mode_i,
   // Display scan port
   input  wire logic       scan_line_i,
   input  wire logic [3:0] scan_pos_i,
   input  wire logic [3:0] scan_row_i,
   output logic      [7:0] scan_code_o,
   output logic      [4:0] scan_pixels_o,
   // Status
   output logic            busy_flag_o
);

   // ---------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------
   // Next counter value; display RAM skips the gap between the lines.
   function automatic logic [6:0] step_ac(input logic [6:0] ac,
                                          input logic       inc,
                                          input logic       glyph);
      logic [6:0] r;
      r = inc ? ac + 7'h01 : ac - 7'h01;
      if (glyph) begin
         r = {1'b0, r[5:0]};
      end else if (inc && ac == `DRAM_LAST1) begin
         r = `DRAM_LINE2;
      end else if (inc && ac == `DRAM_LAST2) begin
         r = 7'h00;
      end else if (!inc && ac == 7'h00) begin
         r = `DRAM_LAST2;
      end else if (!inc && ac == `DRAM_LINE2) begin
         r = `DRAM_LAST1;
      end
      return r;
   endfunction

   // Linear display RAM index of a seven-bit address.
   function automatic logic [6:0] dram_index(input logic [6:0] ac);
      logic [6:0] r;
      r = ac[6] ? {1'b0, `LINE_LEN} + {1'b0, ac[5:0]} : {1'b0, ac[5:0]};
      return (ac[5:0] < `LINE_LEN) ? r : 7'h7F;
   endfunction

   // Stand-in font: the real character shapes are loaded per product.
   // Codes E0H and up are the 32 tall glyphs (eleven rows), codes 10H to
   // DFH the 208 small ones (eight rows); other rows are blank.
   function automatic logic [4:0] glyph_rom(input logic [7:0] code,
                                            input logic [3:0] row);
      logic       tall;
      logic [4:0] r;
      tall = (code[7:5] == 3'h7);
      r    = code[4:0] ^ {row, 1'b0};
      if (row > (tall ? 4'hA : 4'h7)) begin
         r = 5'h00;
      end
      return r;
   endfunction

   // ---------------------------------------------------------------------
   // State
   // ---------------------------------------------------------------------
   logic [7:0]  display_ram [0:`DRAM_WORDS-1];
   logic [7:0]  glyph_ram   [0:`GRAM_WORDS-1];
   eng_state_t  state, next_state;
   logic [6:0]  address_counter, next_address_counter;
   logic        sel_glyph, next_sel_glyph;
   logic        entry_inc, next_entry_inc;
   logic [5:0]  shift_off, next_shift_off;
   logic [7:0]  data_register, next_data_register;
   logic        fetch_pending, next_fetch_pending;
   logic [3:0]  exec_cnt, next_exec_cnt;
   logic        strobe_q, phase, next_phase;
   logic [3:0]  hi_nib, next_hi_nib;
   logic [7:0]  next_bus_o;
   logic        ram_we;
   logic [7:0]  ram_wdata, fetch_byte;
   logic [6:0]  dram_idx;
   host_op_t    push_op, pop_op;
   logic        push_valid, pop_valid, pop_ready;
   logic        strobe_fall, byte_done, busy;
   logic [7:0]  host_byte, read_byte;

   // ---------------------------------------------------------------------
   // Host side
   // ---------------------------------------------------------------------
   // Pending queue entries count as busy so a command never overtakes data.
   assign busy        = (state != ST_IDLE) | pop_valid;
   assign busy_flag_o = busy;
   assign strobe_fall = strobe_q & ~strobe_i;
   assign byte_done   = strobe_fall & (~four_bit_mode_i | phase);
   assign host_byte   = four_bit_mode_i ? {hi_nib, bus_i[7:4]} : bus_i;

   // Decode the finished transfer into a queued operation.
   always_comb begin
      push_valid   = 1'b0;
      push_op      = '{kind: OP_CMD, value: host_byte};
      if (byte_done) begin
         case ({register_select_line_i, read_not_write_i})
            2'b00: begin
               push_valid = ~busy;
            end
            2'b10: begin
               push_valid   = 1'b1;
               push_op.kind = OP_DATA_WR;
            end
            2'b11: begin
               push_valid   = 1'b1;
               push_op.kind = OP_READ_ADV;
            end
            default: begin
               push_valid = 1'b0;
            end
         endcase
      end
   end

   // Nibble phase and the byte presented for reading.
   always_comb begin
      next_phase  = phase;
      next_hi_nib = hi_nib;
      if (!four_bit_mode_i) begin
         next_phase = 1'b0;
      end else if (strobe_fall) begin
         next_phase = ~phase;
         if (!phase) begin
            next_hi_nib = bus_i[7:4];
         end
      end
      read_byte = register_select_line_i ? data_register
                : {busy, address_counter};
      if (four_bit_mode_i) begin
         next_bus_o = phase ? {read_byte[3:0], 4'h0}
                            : {read_byte[7:4], 4'h0};
      end else begin
         next_bus_o = read_byte;
      end
   end

   // Drive only during a read strobe; lower lines stay off in four-bit mode.
   always_comb begin
      bus_oe_b_o = 8'hFF;
      if (strobe_i && read_not_write_i) begin
         bus_oe_b_o = four_bit_mode_i ? 8'h0F : 8'h00;
      end
   end

   // The queue decouples host strobes from RAM timing; when it is full a
   // further data write is dropped, which the busy flag warns against.
   op_fifo #(
      .WIDTH ($bits(host_op_t)),
      .DEPTH (`FIFO_DEPTH)
   ) u_queue (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (push_valid),
      .in_ready_o  (),
      .in_data_i   (push_op),
      .out_valid_o (pop_valid),
      .out_ready_i (pop_ready),
      .out_data_o  (pop_op)
   );

   // ---------------------------------------------------------------------
   // Engine
   // ---------------------------------------------------------------------
   assign pop_ready  = (state == ST_IDLE);
   assign dram_idx   = dram_index(address_counter);
   assign fetch_byte = sel_glyph ? glyph_ram[address_counter[5:0]]
                     : (dram_idx < 7'(`DRAM_WORDS)) ? display_ram[dram_idx]
                     : 8'h00;

   // Execute one queued operation, wait out its time, then prefetch if one is pending.
   always_comb begin
      next_state           = state;
      next_address_counter = address_counter;
      next_sel_glyph       = sel_glyph;
      next_entry_inc       = entry_inc;
      next_shift_off       = shift_off;
      next_data_register   = data_register;
      next_fetch_pending   = fetch_pending;
      next_exec_cnt        = exec_cnt;
      ram_we               = 1'b0;
      ram_wdata            = pop_op.value;
      case (state)
         ST_IDLE: begin
            if (pop_valid) begin
               next_state    = ST_EXEC;
               next_exec_cnt = 4'(`EXEC_CYCLES - 1);
               case (pop_op.kind)
                  OP_DATA_WR: begin
                     ram_we               = 1'b1;
                     next_address_counter = step_ac(address_counter,
                                               entry_inc, sel_glyph);
                  end
                  OP_READ_ADV: begin
                     next_address_counter = step_ac(address_counter,
                                               entry_inc, sel_glyph);
                     next_fetch_pending   = 1'b1;
                  end
                  default: begin
                     if (pop_op.value[`CMD_DRAM_BIT]) begin
                        next_address_counter = pop_op.value[6:0];
                        next_sel_glyph       = 1'b0;
                        next_fetch_pending   = 1'b1;
                     end else if (pop_op.value[`CMD_GRAM_BIT]) begin
                        next_address_counter = {1'b0, pop_op.value[5:0]};
                        next_sel_glyph       = 1'b1;
                        next_fetch_pending   = 1'b1;
                     end else if (pop_op.value[`CMD_SHIFT_BIT]) begin
                        if (!pop_op.value[`SHIFT_DISP_BIT]) begin
                           next_address_counter = step_ac(address_counter,
                              ~pop_op.value[`SHIFT_RIGHT_BIT], sel_glyph);
                        end else if (pop_op.value[`SHIFT_RIGHT_BIT]) begin
                           next_shift_off = (shift_off == 6'h00)
                              ? `LINE_LEN - 6'h01 : shift_off - 6'h01;
                        end else begin
                           next_shift_off = (shift_off == `LINE_LEN - 6'h01)
                              ? 6'h00 : shift_off + 6'h01;
                        end
                     end else if (pop_op.value[`CMD_ENTRY_BIT]) begin
                        next_entry_inc = pop_op.value[`ENTRY_INC_BIT];
                     end
                  end
               endcase
            end
         end
         ST_EXEC: begin
            next_exec_cnt = exec_cnt - 4'h1;
            if (exec_cnt == 4'h0) begin
               next_state = fetch_pending ? ST_FETCH : ST_IDLE;
            end
         end
         ST_FETCH: begin
            next_data_register = fetch_byte;
            next_fetch_pending = 1'b0;
            next_state         = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------------
   // Display scan
   // ---------------------------------------------------------------------
   logic [5:0] scan_low;
   logic [6:0] scan_idx;
   logic [7:0] next_scan_code;
   logic [4:0] next_scan_pixels;

   // Visible window plus shift, wrapped within the 40 bytes of a line.
   always_comb begin
      scan_low = {2'h0, scan_pos_i} + shift_off;
      if (scan_low >= `LINE_LEN) begin
         scan_low = scan_low - `LINE_LEN;
      end
      scan_idx       = scan_line_i ? {1'b0, `LINE_LEN} + {1'b0, scan_low}
                                   : {1'b0, scan_low};
      next_scan_code = display_ram[scan_idx];
      if (next_scan_code[7:4] == 4'h0) begin
         next_scan_pixels = glyph_ram[{next_scan_code[2:0], scan_row_i[2:0]}]
                            [4:0];
      end else begin
         next_scan_pixels = glyph_rom(next_scan_code, scan_row_i);
      end
   end

   // ---------------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state           <= ST_IDLE;
         address_counter <= `AC_RESET;
         sel_glyph       <= 1'b0;
         entry_inc       <= `ENTRY_INC_RESET;
         shift_off       <= `SHIFT_RESET;
         data_register   <= 8'h00;
         fetch_pending   <= 1'b0;
         exec_cnt        <= 4'h0;
         strobe_q        <= 1'b0;
         phase           <= 1'b0;
         hi_nib          <= 4'h0;
         bus_o           <= 8'h00;
         scan_code_o     <= 8'h00;
         scan_pixels_o   <= 5'h00;
      end else begin
         state           <= next_state;
         address_counter <= next_address_counter;
         sel_glyph       <= next_sel_glyph;
         entry_inc       <= next_entry_inc;
         shift_off       <= next_shift_off;
         data_register   <= next_data_register;
         fetch_pending   <= next_fetch_pending;
         exec_cnt        <= next_exec_cnt;
         strobe_q        <= strobe_i;
         phase           <= next_phase;
         hi_nib          <= next_hi_nib;
         bus_o           <= next_bus_o;
         scan_code_o     <= next_scan_code;
         scan_pixels_o   <= next_scan_pixels;
      end
   end

   // RAM writes; out-of-map display addresses are quietly discarded.
   always_ff @(posedge clk_i) begin
      if (ram_we && sel_glyph) begin
         glyph_ram[address_counter[5:0]] <= ram_wdata;
      end
      if (ram_we && !sel_glyph && dram_idx < 7'(`DRAM_WORDS)) begin
         display_ram[dram_idx] <= ram_wdata;
      end
   end

endmodule // char_lcd_host_register_port

`default_nettype wire

// ==== bench/lcd_port_assertions.sv ====
// Checker for the display host port: bus line enables and busy flag.
// Sees only top-level ports; bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------------
// Port checker
// ------------------------------------------------------------------------
module lcd_port_checker (
   // Watched ports
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic       register_select_line_i,
   input wire logic       read_not_write_i,
   input wire logic       strobe_i,
   input wire logic       four_bit_mode_i,
   input wire logic [7:0] bus_o,
   input wire logic [7:0] bus_oe_b_o,
   input wire logic       busy_flag_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // Decodes of an 8-bit read and an 8-bit status selection.
   logic rd8;
   logic stat8;
   assign rd8   = strobe_i && read_not_write_i && !four_bit_mode_i;
   assign stat8 = !register_select_line_i && read_not_write_i
                  && !four_bit_mode_i;

   AST_OE_READ8: assert property (
      rd8 |-> bus_oe_b_o == 8'h00) else $error("8-bit read not driven");
   AST_OE_READ4: assert property (
      strobe_i && read_not_write_i && four_bit_mode_i
      |-> bus_oe_b_o == 8'h0F) else $error("4-bit read enables wrong");
   AST_OE_IDLE: assert property (
      !strobe_i |-> bus_oe_b_o == 8'hFF) else $error("driven, strobe low");
   AST_OE_WRITE: assert property (
      !read_not_write_i |-> bus_oe_b_o == 8'hFF) else $error("drove a write");
   AST_BUSY_STATUS: assert property (
      $past(stat8) && stat8 |-> bus_o[7] == $past(busy_flag_o))
      else $error("status bit 7 is not the busy flag");
   AST_BUSY_RISE: assert property (
      $fell(strobe_i) && register_select_line_i && !read_not_write_i
      && !four_bit_mode_i |=> busy_flag_o) else $error("write not taken");
   AST_BUSY_HOLD: assert property (
      $rose(busy_flag_o) |-> busy_flag_o [*8]) else $error("busy too short");
   AST_BUSY_BOUND: assert property (
      $rose(busy_flag_o) |-> ##[1:200] !busy_flag_o)
      else $error("busy never clears");
   AST_RESET_IDLE: assert property (
      $rose(rst_b_i) |-> !busy_flag_o) else $error("busy after reset");

   // Main scenarios reached.
   cover property (stat8 && busy_flag_o);
   cover property (strobe_i && read_not_write_i && four_bit_mode_i);
   cover property ($fell(strobe_i) && register_select_line_i);
endmodule // lcd_port_checker
`default_nettype wire

// ==== bench/lcd_host_model.sv ====
// Host processor model driving the display port's parallel pins.
// Assumes the bench resolves the shared data lines and feeds bus_i back.
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------------
// Parallel bus host
// ------------------------------------------------------------------------
module lcd_host_model (
   // Clock and bus width strap
   input  wire logic       clk_i,
   input  wire logic       four_bit_i,
   // Resolved data lines
   input  wire logic [7:0] bus_i,
   // Host drive
   output logic            rs_o,
   output logic            rw_o,
   output logic            strobe_o,
   output logic      [7:0] bus_o
);
   // Idle with strobe low.
   initial begin
      rs_o = 1'b0;
      rw_o = 1'b1;
      strobe_o = 1'b0;
      bus_o = 8'h00;
   end

   // One strobed access. Select and direction settle a clock before the
   // strobe and stay two clocks past its fall, so the hold is kept; after
   // that the lines show the inverse, never a stale value.
   task automatic nib(input logic rs, rw, input logic [7:0] v,
                      output logic [7:0] rd);
      @(posedge clk_i);
      rs_o <= rs;
      rw_o <= rw;
      bus_o <= rw ? ~bus_o : v;
      @(posedge clk_i);
      strobe_o <= 1'b1;
      @(posedge clk_i);
      #1 rd = bus_i;
      @(posedge clk_i);
      strobe_o <= 1'b0;
      @(posedge clk_i);
      @(posedge clk_i);
      bus_o <= ~bus_o;
   endtask

   // Whole byte; in four-bit mode the upper half goes first on the upper
   // lines, and the open lower lines carry junk.
   task automatic xfer(input logic rs, rw, input logic [7:0] v,
                       output logic [7:0] rd);
      logic [7:0] hi;
      logic [7:0] lo;
      if (four_bit_i) begin
         nib(rs, rw, {v[7:4], ~v[7:4]}, hi);
         nib(rs, rw, {v[3:0], ~v[3:0]}, lo);
         rd = {hi[7:4], lo[7:4]};
      end else begin
         nib(rs, rw, v, rd);
      end
   endtask
endmodule // lcd_host_model
`default_nettype wire

// ==== bench/test_char_lcd_host_register_port.sv ====
// Self-checking bench for the display host register port.
// Assumes the design package, map header and host model are compiled.
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------------
// Bench top
// ------------------------------------------------------------------------
module test_char_lcd_host_register_port;
   logic       clk_i = 1'b0;
   logic       rst_b_i = 1'b0;
   logic       four_bit = 1'b0;
   logic       scan_line = 1'b0;
   logic [3:0] scan_pos = 4'h0;
   logic       rs, rw, strobe, busy;
   logic [7:0] host_bus, dev_bus, oe_b, bus_lvl, scan_code;
   logic [4:0] scan_pix;
   int         err_count = 0;
   int         num_checks = 0;

   // Each line shows the device where it drives, else the host.
   assign bus_lvl = (~oe_b & dev_bus) | (oe_b & host_bus);

   char_lcd_host_register_port u_char_lcd_host_register_port (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .register_select_line_i(rs),
      .read_not_write_i(rw), .strobe_i(strobe), .bus_i(bus_lvl),
      .bus_o(dev_bus), .bus_oe_b_o(oe_b), .four_bit_mode_i(four_bit),
      .scan_line_i(scan_line), .scan_pos_i(scan_pos), .scan_row_i(4'h0),
      .scan_code_o(scan_code), .scan_pixels_o(scan_pix),
      .busy_flag_o(busy));
   lcd_host_model u_lcd_host_model (
      .clk_i(clk_i), .four_bit_i(four_bit), .bus_i(bus_lvl), .rs_o(rs),
      .rw_o(rw), .strobe_o(strobe), .bus_o(host_bus));

   // 200 MHz clock.
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic sel, input logic [7:0] v);
      logic [7:0] d;
      u_lcd_host_model.xfer(sel, 1'b0, v, d);
   endtask

   task automatic rd(input logic sel, output logic [7:0] v);
      u_lcd_host_model.xfer(sel, 1'b1, 8'h00, v);
   endtask

   // Bounded poll of the status byte until busy reads clear.
   task automatic poll();
      logic [7:0] s;
      int n;
      n = 0;
      s = 8'hFF;
      while (s[7] !== 1'b0 && n < 40) begin
         rd(1'b0, s);
         n++;
      end
      if (n >= 40) chk(s, 8'h00);
   endtask

   task automatic cmd(input logic [7:0] v);
      poll();
      wr(1'b0, v);
   endtask

   task automatic scan(input logic ln, input logic [3:0] p,
                       input logic [7:0] e);
      @(posedge clk_i);
      scan_line <= ln;
      scan_pos <= p;
      repeat (2) @(posedge clk_i);
      #1 chk(scan_code, e);
   endtask

   task automatic t_data();
      logic [7:0] s;
      rd(1'b0, s);
      chk(s, 8'h00);
      cmd(8'hC0);
      wr(1'b1, 8'h5A);
      wr(1'b1, 8'hA5);
      rd(1'b0, s);
      chk({7'h00, s[7]}, 8'h01);
      poll();
      rd(1'b0, s);
      chk(s, 8'h42);
      cmd(8'hC0);
      poll();
      rd(1'b1, s);
      chk(s, 8'h5A);
      poll();
      rd(1'b1, s);
      chk(s, 8'hA5);
      poll();
      rd(1'b0, s);
      chk(s, 8'h42);
      $display("data test done");
   endtask

   task automatic t_cmds();
      logic [7:0] s;
      cmd(8'h04);
      cmd(8'h85);
      wr(1'b1, 8'h33);
      poll();
      rd(1'b0, s);
      chk(s, 8'h04);
      cmd(8'h06);
      cmd(8'h8A);
      wr(1'b0, 8'h8C);
      poll();
      rd(1'b0, s);
      chk(s, 8'h0A);
      cmd(8'h48);
      wr(1'b1, 8'h1F);
      cmd(8'h48);
      poll();
      rd(1'b1, s);
      chk(s, 8'h1F);
      $display("command test done");
   endtask

   task automatic t_scan();
      cmd(8'h80);
      wr(1'b1, 8'h61);
      wr(1'b1, 8'h62);
      cmd(8'hA7);
      wr(1'b1, 8'h63);
      cmd(8'hC0);
      wr(1'b1, 8'h64);
      poll();
      scan(1'b0, 4'h0, 8'h61);
      chk({3'h0, scan_pix}, 8'h01);
      scan(1'b1, 4'h0, 8'h64);
      cmd(8'h18);
      poll();
      scan(1'b0, 4'h0, 8'h62);
      cmd(8'h1C);
      cmd(8'h1C);
      poll();
      scan(1'b0, 4'h0, 8'h63);
      $display("scan test done");
   endtask

   task automatic t_four();
      logic [7:0] s;
      @(posedge clk_i);
      four_bit <= 1'b1;
      @(posedge clk_i);
      cmd(8'hC5);
      wr(1'b1, 8'h9C);
      cmd(8'hC5);
      poll();
      rd(1'b1, s);
      chk(s, 8'h9C);
      poll();
      rd(1'b0, s);
      chk(s, 8'h46);
      four_bit <= 1'b0;
      $display("four-bit test done");
   endtask

   // Reset for 16 clocks, then the scenarios.
   initial begin
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_data();
      t_cmds();
      t_scan();
      t_four();
      finish_test();
   end

   // Watchdog well past the several hundred clocks the scenarios need.
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      finish_test();
   end
endmodule // test_char_lcd_host_register_port

bind char_lcd_host_register_port lcd_port_checker u_lcd_port_checker (
   .clk_i(clk_i), .rst_b_i(rst_b_i),
   .register_select_line_i(register_select_line_i),
   .read_not_write_i(read_not_write_i), .strobe_i(strobe_i),
   .four_bit_mode_i(four_bit_mode_i), .bus_o(bus_o),
   .bus_oe_b_o(bus_oe_b_o), .busy_flag_o(busy_flag_o));
`default_nettype wire
